// file: tilt_can_msg.sv
/*
 * Message layer of the tilt sensor: address claim, angle broadcast, command
 * decode. Assumes a frame-level CAN controller on the same clock that hands
 * over received frames as one-cycle strobes and accepts frames with a
 * valid/ready handshake; angles, faults and serial number come from elsewhere.
 */
//
// Overview of operation
// RULE_01 - frames use 29-bit identifiers: priority, format, specific field, source address
// RULE_02 - bus runs at 250 kbps, handled by the attached controller
// RULE_03 - send one address claim 500 ms after start and on each host request
// RULE_04 - own source address defaults to unassigned, settable in tilt range
// RULE_05 - angle frame priority 4, format 0xFF, specific 0x53, every 10 ms
// RULE_06 - bytes 0-3 carry roll then pitch, signed hundredths, low byte first
// RULE_07 - byte 4 carries signed whole-degree temperature
// RULE_08 - byte 5 carries major version high nibble, minor low nibble
// RULE_09 - byte 6 low nibble: 0 invalid, 1 valid, 3 error
// RULE_10 - invalid status fills bytes 0-5 with 0xFF
// RULE_11 - byte 6 high nibble counts angle frames, wrapping
// RULE_12 - byte 7 bits flag present faults, bits 6-7 zero
// RULE_13 - checksum failure sets bit 0 and error status, data still sent
// RULE_14 - axis element fault sets bit 1 or 2 and forces that axis 0xFFFF
// RULE_15 - undervoltage, overvoltage, overtemperature set bits 3, 4, 5 with error status
// RULE_16 - address claim uses priority 6, format 0xEE, specific 0xFF
// RULE_17 - claim payload: serial and maker code, function 136, industry group 3
// RULE_18 - priority-6 request 0xEA to our address triggers an address claim
// RULE_19 - host commands use priority 4, format 0xFF, specific 0x54
// RULE_20 - host learns serial numbers before assigning addresses
// RULE_21 - command 0x00 makes the sensor reply with its serial frame
// RULE_22 - command 0x01 with matching serial adopts and stores new address
// RULE_23 - command 0x02 silences broadcasts and all replies
// RULE_24 - command 0x03 resumes broadcasts and replies
// RULE_25 - unknown commands and frames for other addresses are ignored
// RULE_26 - after reset broadcasting and answering are enabled
`timescale 1ns/100ps

module tilt_can_msg #(
    parameter int CLAIM_DELAY = tilt_can_pkg::CLAIM_DELAY_CYCLES,
    parameter int ANGLE_PERIOD = tilt_can_pkg::ANGLE_PERIOD_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // received frames from the CAN controller
    input wire logic rxValid,
    input wire tilt_can_pkg::frame_t rxFrame,
    // frames to the CAN controller
    output tilt_can_pkg::frame_t txFrame, // see RULE_02
    output logic txValid,
    input wire logic txReady,
    // measurements and fault flags
    input wire tilt_can_pkg::measure_t measure,
    input wire logic [5:0] faults,
    // identity
    input wire logic [20:0] serialNum,
    input wire logic [10:0] makerCode,
    input wire logic [47:0] serialBcd,
    input wire logic [15:0] swRevBcd,
    // stored address in non-volatile memory
    input wire logic [7:0] storedAddr,
    input wire logic storedLoad,
    output logic [7:0] nvmAddr,
    output logic nvmWrite,
    // status
    output logic [7:0] srcAddr,
    output logic enabled
);

    tilt_can_pkg::state_t s_ff;
    tilt_can_pkg::state_t nxt_s;

    // ------------------------------------------------------------
    // identifier helpers
    // ------------------------------------------------------------
    function automatic logic [28:0] mkId(input logic [2:0] prio, input logic [7:0] pf,
                                         input logic [7:0] ps, input logic [7:0] sa);
        mkId = {prio, 2'h0, pf, ps, sa}; // see RULE_01
    endfunction

    function automatic logic [7:0] fieldPf(input logic [28:0] id);
        fieldPf = id[tilt_can_pkg::ID_PF_MSB:tilt_can_pkg::ID_PF_LSB];
    endfunction

    function automatic logic [7:0] fieldPs(input logic [28:0] id);
        fieldPs = id[tilt_can_pkg::ID_PS_MSB:tilt_can_pkg::ID_PS_LSB];
    endfunction

    function automatic logic [2:0] fieldPrio(input logic [28:0] id);
        fieldPrio = id[tilt_can_pkg::ID_PRIO_MSB:tilt_can_pkg::ID_PRIO_LSB];
    endfunction

    // ------------------------------------------------------------
    // receive decode
    // ------------------------------------------------------------
    logic [7:0] rxCmd;
    logic [7:0] rxArg;
    logic isRequest;
    logic isCommand;
    logic serialMatch;
    logic addrOk;

    assign rxCmd = rxFrame.data[63:56];
    assign rxArg = rxFrame.data[55:48];
    // a request to us: priority 6, 0xEA, our address in PS; byte 1 must also hold 0xEA
    assign isRequest = rxValid && fieldPrio(rxFrame.id) == tilt_can_pkg::PRIO_CLAIM
                       && fieldPf(rxFrame.id) == tilt_can_pkg::PF_REQUEST
                       && fieldPs(rxFrame.id) == s_ff.srcAddr
                       && rxFrame.data[55:48] == tilt_can_pkg::PF_REQUEST; // see RULE_18 RULE_25
    assign isCommand = rxValid && fieldPrio(rxFrame.id) == tilt_can_pkg::PRIO_DATA
                       && fieldPf(rxFrame.id) == tilt_can_pkg::PF_PROP_B
                       && fieldPs(rxFrame.id) == tilt_can_pkg::PS_COMMAND; // see RULE_19
    // target sensor named by its bcd serial in bytes 2-7
    assign serialMatch = rxFrame.data[47:0] == serialBcd; // see RULE_22
    assign addrOk = rxArg >= tilt_can_pkg::SA_RANGE_LO && rxArg <= tilt_can_pkg::SA_RANGE_HI; // see RULE_04

    // ------------------------------------------------------------
    // angle payload
    // ------------------------------------------------------------
    logic anyFault;
    logic [3:0] status;
    logic [15:0] rollOut;
    logic [15:0] pitchOut;
    logic [63:0] anglePayload;
    logic [63:0] claimPayload;

    assign anyFault = |faults; // see RULE_13 RULE_15
    assign status = anyFault ? tilt_can_pkg::ST_ERROR
                  : (measure.valid ? tilt_can_pkg::ST_VALID : tilt_can_pkg::ST_INVALID); // see RULE_09

    always_comb
    begin
        rollOut = faults[tilt_can_pkg::ERR_ROLL] ? tilt_can_pkg::AXIS_FAULT : measure.roll; // see RULE_14
        pitchOut = faults[tilt_can_pkg::ERR_PITCH] ? tilt_can_pkg::AXIS_FAULT : measure.pitch; // see RULE_14
        if (status == tilt_can_pkg::ST_INVALID)
        begin
            // invalid data never looks like a plausible angle
            anglePayload[63:16] = {6{tilt_can_pkg::FILL_BYTE}}; // see RULE_10
        end
        else
        begin
            anglePayload[63:16] = {rollOut[7:0], rollOut[15:8], pitchOut[7:0], pitchOut[15:8],
                                   measure.temp, measure.version}; // see RULE_06 RULE_07 RULE_08
        end
        anglePayload[15:8] = {s_ff.stamp, status}; // see RULE_11
        anglePayload[7:0] = {2'h0, faults}; // see RULE_12
    end

    // byte 0 is sent first, so it sits in the top byte of data
    assign claimPayload = {serialNum[7:0], serialNum[15:8], makerCode[2:0], serialNum[20:16],
                           makerCode[10:3], tilt_can_pkg::CLAIM_INSTANCE, tilt_can_pkg::CLAIM_FUNCTION,
                           tilt_can_pkg::CLAIM_VSYS, tilt_can_pkg::CLAIM_BYTE7}; // see RULE_17

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.nvmWrite = 1'b0;

        // startup claim timer, runs once
        if (!s_ff.claimDone)
        begin
            if (s_ff.startCnt == 32'(CLAIM_DELAY - 1))
            begin
                nxt_s.claimDone = 1'b1;
                nxt_s.claimPend = 1'b1; // see RULE_03
            end
            else
            begin
                nxt_s.startCnt = s_ff.startCnt + 32'h1;
            end
        end

        // angle period timer
        if (s_ff.periodCnt == 32'(ANGLE_PERIOD - 1))
        begin
            nxt_s.periodCnt = 32'h0;
            nxt_s.anglePend = 1'b1; // see RULE_05
        end
        else
        begin
            nxt_s.periodCnt = s_ff.periodCnt + 32'h1;
        end

        if (storedLoad)
        begin
            nxt_s.srcAddr = storedAddr;
        end

        if (isRequest)
        begin
            nxt_s.claimPend = 1'b1; // see RULE_18
        end

        if (isCommand)
        begin
            unique case (rxCmd)
                tilt_can_pkg::CMD_SERIAL: nxt_s.serialPend = 1'b1; // see RULE_21
                tilt_can_pkg::CMD_SET_SA:
                begin
                    if (serialMatch && addrOk)
                    begin
                        nxt_s.srcAddr = rxArg; // see RULE_22
                        nxt_s.nvmAddr = rxArg;
                        nxt_s.nvmWrite = 1'b1;
                    end
                end
                tilt_can_pkg::CMD_WAIT: nxt_s.enabled = 1'b0; // see RULE_23
                tilt_can_pkg::CMD_RESUME: nxt_s.enabled = 1'b1; // see RULE_24
                default: ; // see RULE_25
            endcase
        end

        // transmit: claim before serial before angle
        if (s_ff.txValid)
        begin
            if (txReady)
            begin
                nxt_s.txValid = 1'b0;
                if (s_ff.txSel == tilt_can_pkg::SEL_ANGLE)
                begin
                    nxt_s.stamp = s_ff.stamp + 4'h1; // see RULE_11
                end
            end
        end
        else if (!s_ff.enabled)
        begin
            // silenced: pending work is dropped, not replayed on resume
            nxt_s.claimPend = 1'b0; // see RULE_23
            nxt_s.serialPend = 1'b0;
            nxt_s.anglePend = 1'b0;
        end
        else if (s_ff.claimPend)
        begin
            nxt_s.claimPend = 1'b0;
            nxt_s.txValid = 1'b1;
            nxt_s.txSel = tilt_can_pkg::SEL_CLAIM;
            nxt_s.txFrame.id = mkId(tilt_can_pkg::PRIO_CLAIM, tilt_can_pkg::PF_CLAIM,
                                    tilt_can_pkg::PS_GLOBAL, s_ff.srcAddr); // see RULE_16
            nxt_s.txFrame.data = claimPayload;
        end
        else if (s_ff.serialPend)
        begin
            nxt_s.serialPend = 1'b0;
            nxt_s.txValid = 1'b1;
            nxt_s.txSel = tilt_can_pkg::SEL_SERIAL;
            nxt_s.txFrame.id = mkId(tilt_can_pkg::PRIO_DATA, tilt_can_pkg::PF_PROP_B,
                                    tilt_can_pkg::PS_SERIAL, s_ff.srcAddr); // see RULE_21
            nxt_s.txFrame.data = {serialBcd, swRevBcd};
        end
        else if (s_ff.anglePend)
        begin
            nxt_s.anglePend = 1'b0;
            nxt_s.txValid = 1'b1;
            nxt_s.txSel = tilt_can_pkg::SEL_ANGLE;
            nxt_s.txFrame.id = mkId(tilt_can_pkg::PRIO_DATA, tilt_can_pkg::PF_PROP_B,
                                    tilt_can_pkg::PS_ANGLE, s_ff.srcAddr); // see RULE_05
            nxt_s.txFrame.data = anglePayload;
        end

        // a request arriving while silenced stays unanswered
        if (!nxt_s.enabled)
        begin
            nxt_s.claimPend = 1'b0; // see RULE_23
            nxt_s.serialPend = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_ff <= '0;
            s_ff.enabled <= 1'b1; // see RULE_26
            s_ff.srcAddr <= tilt_can_pkg::SA_UNASSIGNED; // see RULE_04
            s_ff.nvmAddr <= tilt_can_pkg::SA_UNASSIGNED;
            s_ff.txSel <= tilt_can_pkg::SEL_NONE;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    assign txFrame = s_ff.txFrame;
    assign txValid = s_ff.txValid;
    assign nvmAddr = s_ff.nvmAddr;
    assign nvmWrite = s_ff.nvmWrite;
    assign srcAddr = s_ff.srcAddr;
    assign enabled = s_ff.enabled;

endmodule

// file: tilt_can_pkg.sv
/*
 * Shared constants and carrier types for the tilt sensor CAN message layer.
 * Assumes a separate bit-level CAN controller that moves whole frames.
 */
package tilt_can_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLOCK_MHZ = 250;
    localparam int CLAIM_DELAY_MS = 500;
    localparam int ANGLE_PERIOD_MS = 10;
    localparam int CLAIM_DELAY_CYCLES = CLAIM_DELAY_MS * 1000 * CLOCK_MHZ;
    localparam int ANGLE_PERIOD_CYCLES = ANGLE_PERIOD_MS * 1000 * CLOCK_MHZ;
    localparam int BIT_RATE_KBPS = 250;

    // ------------------------------------------------------------
    // identifier layout
    // ------------------------------------------------------------
    localparam int ID_PRIO_LSB = 26;
    localparam int ID_PF_LSB = 16;
    localparam int ID_PS_LSB = 8;
    localparam int ID_PRIO_MSB = 28;
    localparam int ID_PF_MSB = 23;
    localparam int ID_PS_MSB = 15;
    localparam int ID_SA_MSB = 7;

    localparam logic [2:0] PRIO_DATA = 3'h4;
    localparam logic [2:0] PRIO_CLAIM = 3'h6;
    localparam logic [7:0] PF_PROP_B = 8'hFF;
    localparam logic [7:0] PF_CLAIM = 8'hEE;
    localparam logic [7:0] PF_REQUEST = 8'hEA;
    localparam logic [7:0] PS_GLOBAL = 8'hFF;
    localparam logic [7:0] PS_SERIAL = 8'h52;
    localparam logic [7:0] PS_ANGLE = 8'h53;
    localparam logic [7:0] PS_COMMAND = 8'h54;

    localparam logic [7:0] SA_UNASSIGNED = 8'hC0;
    localparam logic [7:0] SA_RANGE_LO = 8'h80;
    localparam logic [7:0] SA_RANGE_HI = 8'hF7;

    // ------------------------------------------------------------
    // commands and payload fields
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_SERIAL = 8'h00;
    localparam logic [7:0] CMD_SET_SA = 8'h01;
    localparam logic [7:0] CMD_WAIT = 8'h02;
    localparam logic [7:0] CMD_RESUME = 8'h03;

    localparam logic [3:0] ST_INVALID = 4'h0;
    localparam logic [3:0] ST_VALID = 4'h1;
    localparam logic [3:0] ST_ERROR = 4'h3;
    localparam logic [7:0] FILL_BYTE = 8'hFF;
    localparam logic [15:0] AXIS_FAULT = 16'hFFFF;

    localparam int ERR_NVM = 0;
    localparam int ERR_ROLL = 1;
    localparam int ERR_PITCH = 2;
    localparam int ERR_UNDERV = 3;
    localparam int ERR_OVERV = 4;
    localparam int ERR_OVERT = 5;
    localparam int ERR_BITS = 6;

    localparam logic [7:0] CLAIM_INSTANCE = 8'h00;
    localparam logic [7:0] CLAIM_FUNCTION = 8'h88;
    localparam logic [7:0] CLAIM_VSYS = 8'h00;
    localparam logic [7:0] CLAIM_BYTE7 = 8'h30;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [28:0] id;
        logic [63:0] data;
    } frame_t;

    typedef struct packed {
        logic signed [15:0] roll;
        logic signed [15:0] pitch;
        logic signed [7:0] temp;
        logic [7:0] version;
        logic valid;
    } measure_t;

    typedef enum logic [1:0] {SEL_NONE, SEL_CLAIM, SEL_SERIAL, SEL_ANGLE} txsel_t;

    typedef struct packed {
        logic [31:0] startCnt;
        logic claimDone;
        logic [31:0] periodCnt;
        logic claimPend;
        logic serialPend;
        logic anglePend;
        logic [3:0] stamp;
        logic enabled;
        logic [7:0] srcAddr;
        logic [7:0] nvmAddr;
        logic nvmWrite;
        logic txValid;
        frame_t txFrame;
        txsel_t txSel;
    } state_t;

endpackage

// file: tilt_can_msg_sva.sv
/*
 * Port checker for tilt_can_msg, bound to every instance.
 * Assumes one clock domain and the asynchronous active-low reset.
 */
`timescale 1ns/100ps
module tilt_can_msg_sva (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // frame traffic
    input wire logic rxValid,
    input wire tilt_can_pkg::frame_t rxFrame,
    input wire tilt_can_pkg::frame_t txFrame,
    input wire logic txValid,
    input wire logic txReady,
    // identity and address
    input wire logic [47:0] serialBcd,
    input wire logic [7:0] nvmAddr,
    input wire logic nvmWrite,
    input wire logic [7:0] srcAddr,
    input wire logic enabled
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    wire angle = txValid && txFrame.id[15:8] == 8'h53;
    wire req = rxValid && rxFrame.id[28:16] == 13'h18EA && rxFrame.id[15:8] == srcAddr && rxFrame.data[55:48] == 8'hEA;
    wire setSa = rxValid && rxFrame.id[28:8] == 21'h10FF54 && rxFrame.data[63:56] == 8'h01
        && rxFrame.data[55:48] inside {[8'h80:8'hF7]} && rxFrame.data[47:0] == serialBcd;
    logic [3:0] lastStamp;
    logic seenAngle;

    // stamp of the last accepted angle frame
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            seenAngle <= 1'b0;
            lastStamp <= 4'h0;
        end
        else if (angle && txReady)
        begin
            seenAngle <= 1'b1;
            lastStamp <= txFrame.data[15:12];
        end
    end

    property p_resetVals;
        $rose(reset_n) |-> srcAddr == 8'hC0 && enabled && !txValid;
    endproperty
    a_resetVals: assert property (p_resetVals) else $error("reset state wrong");
    property p_txHold;
        txValid && !txReady |=> txValid && $stable(txFrame);
    endproperty
    a_txHold: assert property (p_txHold) else $error("offered frame dropped");
    property p_angleId;
        angle |-> txFrame.id[28:16] == 13'h10FF;
    endproperty
    a_angleId: assert property (p_angleId) else $error("angle id wrong");
    property p_claimId;
        txValid && txFrame.id[23:16] == 8'hEE |-> txFrame.id[28:26] == 3'h6 && txFrame.id[15:8] == 8'hFF
            && txFrame.data[31:0] == 32'h00880030;
    endproperty
    a_claimId: assert property (p_claimId) else $error("claim frame wrong");
    property p_invalidFill;
        angle && txFrame.data[11:8] == 4'h0 |-> txFrame.data[63:16] == {6{8'hFF}};
    endproperty
    a_invalidFill: assert property (p_invalidFill) else $error("invalid fill wrong");
    property p_errStatus;
        angle && txFrame.data[5:0] != 6'h00 |-> txFrame.data[11:8] == 4'h3 && txFrame.data[7:6] == 2'h0;
    endproperty
    a_errStatus: assert property (p_errStatus) else $error("error status wrong");
    property p_silent;
        !enabled && !txValid && !rxValid |=> !txValid;
    endproperty
    a_silent: assert property (p_silent) else $error("frame while silenced");
    property p_setSa;
        setSa |=> srcAddr == $past(rxFrame.data[55:48]) && nvmAddr == srcAddr && nvmWrite ##1 !nvmWrite;
    endproperty
    a_setSa: assert property (p_setSa) else $error("address change wrong");
    property p_request;
        req && enabled |-> ##[1:40] txValid && txFrame.id[23:16] == 8'hEE;
    endproperty
    a_request: assert property (p_request) else $error("claim not answered");
    property p_stamp;
        angle && txReady |-> txFrame.data[15:12] == (seenAngle ? lastStamp + 4'h1 : 4'h0);
    endproperty
    a_stamp: assert property (p_stamp) else $error("stamp out of step");
    c_claim: cover property (txValid && txReady && txFrame.id[23:16] == 8'hEE);
    c_fault: cover property (angle && txFrame.data[11:8] == 4'h3);
    c_silent: cover property (!enabled);
endmodule

bind tilt_can_msg tilt_can_msg_sva tilt_can_msg_sva_i (.clock(clock), .reset_n(reset_n), .rxValid(rxValid),
    .rxFrame(rxFrame), .txFrame(txFrame), .txValid(txValid), .txReady(txReady), .serialBcd(serialBcd),
    .nvmAddr(nvmAddr), .nvmWrite(nvmWrite), .srcAddr(srcAddr), .enabled(enabled));

// file: host_node_model.sv
/*
 * Host node model: sends whole frames to the sensor and accepts the
 * sensor's frames after holdCycles wait states. Same clock as the sensor.
 */
`timescale 1ns/100ps
module host_node_model (
    // clock
    input wire logic clock,
    // sensor transmit side
    input wire tilt_can_pkg::frame_t txFrame,
    input wire logic txValid,
    output logic txReady,
    // sensor receive side
    output logic rxValid,
    output tilt_can_pkg::frame_t rxFrame,
    // test control
    input wire logic [3:0] holdCycles
);
    tilt_can_pkg::frame_t lastFrame;
    int frameCnt = 0;
    logic [3:0] waitCnt = 4'h0;

    assign txReady = txValid && waitCnt >= holdCycles;
    always @(posedge clock)
    begin
        waitCnt <= (txValid && !txReady) ? waitCnt + 4'h1 : 4'h0;
        if (txValid && txReady)
        begin
            lastFrame <= txFrame;
            frameCnt <= frameCnt + 1;
        end
    end

    initial
    begin
        rxValid = 1'b0;
        rxFrame = '0;
    end

    // released bus shows the inverse so a stale frame cannot pass
    task automatic send(input tilt_can_pkg::frame_t f);
        @(posedge clock);
        #1 rxValid = 1'b1;
        rxFrame = f;
        @(posedge clock);
        #1 rxValid = 1'b0;
        rxFrame = ~f;
    endtask
endmodule

// file: tilt_can_msg_test.sv
/*
 * Self-checking bench for tilt_can_msg with the host node model.
 * Short claim and period counts keep the run brief.
 */
`timescale 1ns/100ps
module tilt_can_msg_test;
    localparam int CLAIM = 200;
    localparam int PERIOD = 50;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic rxValid, txValid, txReady, nvmWrite, enabled;
    tilt_can_pkg::frame_t rxFrame, txFrame, got, f1;
    tilt_can_pkg::measure_t measure = {16'hDCD8, 16'h1194, 8'hD8, 8'h3C, 1'b1};
    logic [5:0] faults = 6'h00;
    logic [20:0] serialNum = 21'h1A2B3C;
    logic [10:0] makerCode = 11'h5A5;
    logic [47:0] serialBcd = 48'h001747002860;
    logic [15:0] swRevBcd = 16'h0136;
    logic [7:0] nvmAddr, srcAddr;
    logic [3:0] holdCycles = 4'h0;
    time tRel, gotTime, t1;
    int errorCnt = 0;
    int numChecks = 0;
    int c;

    tilt_can_msg #(.CLAIM_DELAY(CLAIM), .ANGLE_PERIOD(PERIOD)) tilt_can_msg_i (.clock(clock), .reset_n(reset_n),
        .rxValid(rxValid), .rxFrame(rxFrame), .txFrame(txFrame), .txValid(txValid), .txReady(txReady),
        .measure(measure), .faults(faults), .serialNum(serialNum), .makerCode(makerCode), .serialBcd(serialBcd),
        .swRevBcd(swRevBcd), .storedAddr(8'hC0), .storedLoad(1'b0), .nvmAddr(nvmAddr), .nvmWrite(nvmWrite),
        .srcAddr(srcAddr), .enabled(enabled));
    host_node_model host_node_model_i (.clock(clock), .txFrame(txFrame), .txValid(txValid), .txReady(txReady),
        .rxValid(rxValid), .rxFrame(rxFrame), .holdCycles(holdCycles));

    initial
        forever #2 clock = ~clock;

    task automatic check(input logic [63:0] act, input logic [63:0] exp);
        numChecks++;
        if (act !== exp)
        begin
            errorCnt++;
            $display("unexpected at %0t: got %h, expected %h", $time, act, exp);
        end
    endtask

    // got stays all ones when no matching frame is accepted in time
    task automatic wait_frame(input logic [7:0] ps, input int lim);
        int n;
        n = host_node_model_i.frameCnt;
        got = '1;
        repeat (lim)
        begin
            @(posedge clock);
            #1;
            if (host_node_model_i.frameCnt != n && host_node_model_i.lastFrame.id[15:8] == ps)
            begin
                got = host_node_model_i.lastFrame;
                gotTime = $time;
                return;
            end
            n = host_node_model_i.frameCnt;
        end
    endtask

    task automatic command(input logic [63:0] d);
        host_node_model_i.send({29'h10FF54C3, d});
    endtask

    task automatic t_start();
        check(srcAddr, 8'hC0);
        check(enabled, 1'b1);
        wait_frame(8'hFF, CLAIM + 20);
        c = int'((gotTime - tRel) / 4);
        check(c >= CLAIM && c <= CLAIM + 4, 1'b1);
        check(got.id, 29'h18EEFFC0);
        // serial number goes out low byte first
        f1.data = {serialNum[7:0], serialNum[15:8], makerCode[2:0], serialNum[20:16], makerCode[10:3], 32'h00880030};
        check(got.data, f1.data);
        wait_frame(8'hFF, 2 * CLAIM);
        check(got.id, 29'h1FFFFFFF);
    endtask

    task automatic t_angle();
        wait_frame(8'h53, PERIOD + 10);
        wait_frame(8'h53, PERIOD + 10);
        f1 = got;
        t1 = gotTime;
        wait_frame(8'h53, PERIOD + 10);
        check(got.id, 29'h10FF53C0);
        check(gotTime - t1, PERIOD * 4);
        check(got.data[63:16], 48'hD8DC9411D83C);
        check(got.data[11:0], 12'h100);
        check(got.data[15:12], 4'(f1.data[15:12] + 4'h1));
    endtask

    task automatic t_invalid();
        measure.valid = 1'b0;
        wait_frame(8'h53, PERIOD + 10);
        wait_frame(8'h53, PERIOD + 10);
        check(got.data[63:16], 48'hFFFFFFFFFFFF);
        check(got.data[11:0], 12'h000);
        measure.valid = 1'b1;
    endtask

    task automatic t_faults();
        holdCycles = 4'h2;
        for (int b = 0; b < 6; b++)
        begin
            faults = 6'h01 << b;
            wait_frame(8'h53, PERIOD + 10);
            wait_frame(8'h53, PERIOD + 10);
            check(got.data[63:16], {b==1 ? 16'hFFFF : 16'hD8DC, b==2 ? 16'hFFFF : 16'h9411, 16'hD83C});
            check(got.data[11:0], {4'h3, 2'h0, faults});
        end
        faults = 6'h00;
        holdCycles = 4'h0;
    endtask

    task automatic t_request();
        host_node_model_i.send({29'h18EAC7C3, 64'h00EA000000000000});
        wait_frame(8'hFF, 60);
        check(got.id, 29'h1FFFFFFF);
        host_node_model_i.send({29'h18EAC0C3, 64'h00EA000000000000});
        wait_frame(8'hFF, 60);
        check(got.id, 29'h18EEFFC0);
    endtask

    task automatic t_serial();
        command(64'h07FFFFFFFFFFFFFF);
        wait_frame(8'h52, 60);
        check(got.id, 29'h1FFFFFFF);
        command(64'h00FFFFFFFFFFFFFF);
        wait_frame(8'h52, 60);
        check(got.id, 29'h10FF52C0);
        check(got.data, {serialBcd, swRevBcd});
    endtask

    // serial learned first, then address given by serial match
    task automatic t_setSa();
        command({8'h01, 8'h85, serialBcd ^ 48'h1});
        check(srcAddr, 8'hC0);
        command({8'h01, 8'h85, serialBcd});
        check({nvmWrite, nvmAddr, srcAddr}, 17'h18585);
        @(posedge clock);
        #1 check(nvmWrite, 1'b0);
        wait_frame(8'h53, PERIOD + 10);
        check(got.id, 29'h10FF5385);
    endtask

    task automatic t_silence();
        command(64'h02FFFFFFFFFFFFFF);
        check(enabled, 1'b0);
        repeat (2) @(posedge clock);
        #1 c = host_node_model_i.frameCnt;
        command(64'h00FFFFFFFFFFFFFF);
        host_node_model_i.send({29'h18EA85C3, 64'h00EA000000000000});
        repeat (3 * PERIOD) @(posedge clock);
        check(host_node_model_i.frameCnt, c);
        command(64'h03FFFFFFFFFFFFFF);
        check(enabled, 1'b1);
        wait_frame(8'h53, PERIOD + 10);
        check(got.id, 29'h10FF5385);
        command(64'h00FFFFFFFFFFFFFF);
        wait_frame(8'h52, 60);
        check(got.id, 29'h10FF5285);
    endtask

    task automatic stop_test();
        $display("checks %0d, errors %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        #40000;
        errorCnt++;
        stop_test();
    end

    initial
    begin
        repeat (4) @(posedge clock);
        #1 reset_n = 1'b1;
        tRel = $time;
        t_start();
        t_angle();
        t_invalid();
        t_faults();
        t_request();
        t_serial();
        t_setSa();
        t_silence();
        stop_test();
    end
endmodule
